// *** core/modbus_map_access.sv ***
// Request interpreter for the bit and 16-bit mapping areas.
// Assumes a byte transport that marks frame ends and takes reply bytes.
`timescale 1ns/1ns
`include "modbus_map_params.svh"

module modbus_map_access
  import modbus_map_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             own_addr,
  input  wire logic [`AREA_DEPTH-1:0] coil_mapped,
  input  wire logic [`AREA_DEPTH-1:0] reg_mapped,
  input  wire logic                   rx_valid,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   rx_end,
  output logic                        tx_valid,
  output logic      [7:0]             tx_data,
  output logic                        tx_last,
  input  wire logic                   tx_ready,
  input  wire area_wr_t               upd,
  input  wire logic                   upd_valid,
  output logic                        upd_ready,
  output area_wr_t                    dn,
  output logic                        dn_valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t      state, next_state, ret, next_ret;
  logic [8:0]  ptr, next_ptr;
  logic        ovf, next_ovf;
  logic [15:0] crc_rx, next_crc_rx, crc_tx, next_crc_tx;
  logic [7:0]  dev, next_dev, fn, next_fn, bcount, next_bcount;
  logic [15:0] start, next_start, qty, next_qty;
  logic [8:0]  cur, next_cur;
  logic [15:0] left, next_left, word, next_word;
  logic [2:0]  bitn, next_bitn, hidx, next_hidx, hlen, next_hlen;
  logic [7:0]  acc, next_acc, bufp, next_bufp, b2, next_b2;
  logic        exc, next_exc, last, next_last;
  logic [7:0]  txd, next_txd;
  area_wr_t    next_dn;
  logic        next_dn_valid;

  logic [15:0] crc_rx_out, crc_tx_out, word_rd, idx16, n, qty_bytes;
  logic [16:0] span;
  logic [7:0]  buf_rd, head, code, rb, acc_set;
  logic        bit_rd, single, in_range, frame_ok, known, len_ok, val_ok;
  logic        eng_bit_we, eng_word_we, bit_val, upd_take;
  logic [15:0] eng_word;

  // ----------------------------------------------------------------
  // Storage and frame check
  // ----------------------------------------------------------------
  map_memory #(.WIDTH(8), .DEPTH(`RX_DEPTH), .AW(8)) u_rxbuf
  (
    .clk(clk), .rst(rst), .wr_en(state == st_recv && rx_valid && !ptr[8]),
    .wr_addr(ptr[7:0]), .wr_data(rx_data), .rd_addr(next_bufp), .rd_data(buf_rd)
  );

  // Bit area; poll updates keep it a copy of the slaves
  map_memory #(.WIDTH(1), .DEPTH(`AREA_DEPTH), .AW(9)) u_bits
  (
    .clk(clk), .rst(rst), .wr_en(eng_bit_we || (upd_take && upd.is_bit)),
    .wr_addr(eng_bit_we ? cur : upd.index), .wr_data(eng_bit_we ? bit_val : upd.value[0]),
    .rd_addr(next_cur), .rd_data(bit_rd)
  );

  map_memory #(.WIDTH(16), .DEPTH(`AREA_DEPTH), .AW(9)) u_words
  (
    .clk(clk), .rst(rst), .wr_en(eng_word_we || (upd_take && !upd.is_bit)),
    .wr_addr(eng_word_we ? cur : upd.index), .wr_data(eng_word_we ? eng_word : upd.value),
    .rd_addr(next_cur), .rd_data(word_rd)
  );

  crc16_byte u_crc_rx (.crc_in(crc_rx), .data(rx_data), .crc_out(crc_rx_out));
  crc16_byte u_crc_tx (.crc_in(crc_tx), .data(txd), .crc_out(crc_tx_out));

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Poll updates stall in the engine's write states, st_wbit and st_wword
  assign upd_ready = !(state == st_wbit || state == st_wword);
  assign upd_take  = upd_valid && upd_ready;
  assign single    = (fn == `FN_WRITE_BIT) || (fn == `FN_WRITE_WORD);
  assign n         = single ? 16'h0001 : qty;
  assign span      = {1'b0, start} + {1'b0, n};
  assign idx16     = start - `AREA_BASE;
  assign qty_bytes = (qty + 16'h0007) >> 3;
  assign in_range  = (start >= `AREA_BASE) && (span <= {1'b0, `AREA_LIMIT});
  // Residue over data and CRC is zero for a good frame
  assign frame_ok  = (ptr >= `MIN_LEN) && !ovf && (crc_rx == 16'h0000)
                   && (dev == own_addr) && (own_addr >= `DEV_ADDR_MIN)
                   && (own_addr <= `DEV_ADDR_MAX);
  assign rb        = (fn == `FN_READ_BITS) ? qty_bytes[7:0] : {qty[6:0], 1'b0};
  assign acc_set   = acc | ({7'h00, bit_rd} << bitn);

  always_comb
  begin
    known  = 1'b1;
    len_ok = (ptr == `FIXED_LEN);
    val_ok = 1'b1;
    case (fn)
      `FN_READ_BITS:   val_ok = (qty != 16'h0000) && (qty <= `MAX_READ_BITS);
      `FN_READ_WORDS:  val_ok = (qty != 16'h0000) && (qty <= `MAX_READ_WORDS);
      `FN_WRITE_BIT:   val_ok = (qty == `COIL_ON) || (qty == `COIL_OFF);
      `FN_WRITE_WORD:  val_ok = 1'b1;
      `FN_WRITE_BITS:
      begin
        len_ok = (ptr == {1'b0, bcount} + `MULTI_OVERHEAD);
        val_ok = (qty != 16'h0000) && (qty <= `MAX_WRITE_BITS)
               && (bcount == qty_bytes[7:0]);
      end
      `FN_WRITE_WORDS:
      begin
        len_ok = (ptr == {1'b0, bcount} + `MULTI_OVERHEAD);
        val_ok = (qty != 16'h0000) && (qty <= `MAX_WRITE_WORDS)
               && (bcount == {qty[6:0], 1'b0});
      end
      default:         known = 1'b0;
    endcase
    // Malformed length of 4 to 256 bytes is reported as a bad value, not dropped
    code = !known ? `EXC_FUNC : !(len_ok && val_ok) ? `EXC_VALUE
         : !in_range ? `EXC_ADDR : `EXC_NONE;
  end

  always_comb
  begin
    case (hidx)
      3'h0:    head = dev;
      3'h1:    head = exc ? (fn | `EXC_FLAG) : fn;
      3'h2:    head = b2;
      3'h3:    head = start[7:0];
      3'h4:    head = qty[15:8];
      default: head = qty[7:0];
    endcase
  end

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;    next_ret = ret;       next_ptr = ptr;
    next_ovf = ovf;        next_crc_rx = crc_rx; next_crc_tx = crc_tx;
    next_dev = dev;        next_fn = fn;         next_bcount = bcount;
    next_start = start;    next_qty = qty;       next_cur = cur;
    next_left = left;      next_word = word;     next_bitn = bitn;
    next_hidx = hidx;      next_hlen = hlen;     next_acc = acc;
    next_bufp = bufp;      next_b2 = b2;         next_exc = exc;
    next_last = last;      next_txd = txd;
    next_dn = dn;          next_dn_valid = 1'b0;
    eng_bit_we = 1'b0;     eng_word_we = 1'b0;
    bit_val = (fn == `FN_WRITE_BIT) ? (qty == `COIL_ON) : buf_rd[bitn];
    eng_word = (fn == `FN_WRITE_WORD) ? qty : {word[15:8], buf_rd};
    tx_valid = 1'b0;
    case (state)
      st_recv:
      begin
        // Bytes arriving during a reply are ignored
        if (rx_valid)
        begin
          next_crc_rx = crc_rx_out;
          if (ptr[8])
            next_ovf = 1'b1;
          else
            next_ptr = ptr + 9'h001;
          case (ptr)
            `POS_DEV:      next_dev = rx_data;
            `POS_FN:       next_fn = rx_data;
            `POS_START_HI: next_start[15:8] = rx_data;
            `POS_START_LO: next_start[7:0] = rx_data;
            `POS_QTY_HI:   next_qty[15:8] = rx_data;
            `POS_QTY_LO:   next_qty[7:0] = rx_data;
            `POS_BCOUNT:   next_bcount = rx_data;
            default:       next_bcount = bcount;
          endcase
        end
        if (rx_end)
          next_state = st_check;
      end
      st_check:
      begin
        next_ptr = 9'h000;     next_ovf = 1'b0;      next_crc_rx = `CRC_INIT;
        next_crc_tx = `CRC_INIT;
        next_hidx = 3'h0;      next_cur = idx16[8:0]; next_left = n;
        next_bitn = 3'h0;      next_acc = 8'h00;     next_bufp = `DATA_START;
        next_last = 1'b0;      next_exc = 1'b0;
        if (!frame_ok)
          next_state = st_recv;
        else if (code != `EXC_NONE)
        begin
          next_exc = 1'b1;     next_hlen = `HEAD_SHORT;
          next_b2 = code;      next_state = st_head;
        end
        else if (fn == `FN_READ_BITS || fn == `FN_READ_WORDS)
        begin
          next_hlen = `HEAD_SHORT;
          next_b2 = rb;        next_state = st_head;
        end
        else
        begin
          next_hlen = `HEAD_LONG;
          next_b2 = start[15:8];
          next_state = (single ? (fn == `FN_WRITE_BIT) : (fn == `FN_WRITE_BITS))
                     ? st_wbit : st_wword;
        end
      end
      st_head:
      begin
        if (hidx < hlen)
        begin
          next_txd = head;     next_hidx = hidx + 3'h1;
          next_ret = st_head;  next_state = st_tx;
        end
        else if (!exc && fn == `FN_READ_BITS)
          next_state = st_bits;
        else if (!exc && fn == `FN_READ_WORDS)
          next_state = st_words;
        else
          next_state = st_crcl;
      end
      st_bits:
      begin
        next_cur = cur + 9'h001;  next_left = left - 16'h0001;
        next_bitn = bitn + 3'h1;  next_acc = acc_set;
        if (left == 16'h0001 || bitn == 3'h7)
        begin
          // Cleared accumulator leaves unread positions zero
          next_txd = acc_set;  next_acc = 8'h00;  next_bitn = 3'h0;
          next_ret = (left == 16'h0001) ? st_crcl : st_bits;
          next_state = st_tx;
        end
      end
      st_words:
      begin
        next_txd = word_rd[15:8];  next_word = word_rd;
        next_ret = st_wlo;         next_state = st_tx;
      end
      st_wlo:
      begin
        next_txd = word[7:0];
        next_cur = cur + 9'h001;   next_left = left - 16'h0001;
        next_ret = (left == 16'h0001) ? st_crcl : st_words;
        next_state = st_tx;
      end
      st_wbit:
      begin
        eng_bit_we = 1'b1;
        next_dn = '{is_bit: 1'b1, index: cur, value: {15'h0000, bit_val}};
        next_dn_valid = coil_mapped[cur];
        next_cur = cur + 9'h001;   next_left = left - 16'h0001;
        next_bitn = bitn + 3'h1;
        if (bitn == 3'h7)
          next_bufp = bufp + 8'h01;
        if (left == 16'h0001)
          next_state = st_head;
      end
      st_wword:
      begin
        if (fn != `FN_WRITE_WORD && !bitn[0])
        begin
          next_word[15:8] = buf_rd;  next_bufp = bufp + 8'h01;
          next_bitn = 3'h1;
        end
        else
        begin
          eng_word_we = 1'b1;
          next_dn = '{is_bit: 1'b0, index: cur, value: eng_word};
          next_dn_valid = reg_mapped[cur];
          next_bufp = bufp + 8'h01;  next_bitn = 3'h0;
          next_cur = cur + 9'h001;   next_left = left - 16'h0001;
          if (left == 16'h0001)
            next_state = st_head;
        end
      end
      st_crcl:
      begin
        next_txd = crc_tx[7:0];  next_word = {8'h00, crc_tx[15:8]};
        next_ret = st_crch;      next_state = st_tx;
      end
      st_crch:
      begin
        next_txd = word[7:0];    next_last = 1'b1;
        next_ret = st_recv;      next_state = st_tx;
      end
      st_tx:
      begin
        tx_valid = 1'b1;
        if (tx_ready)
        begin
          next_crc_tx = crc_tx_out;
          next_state = ret;
        end
      end
      default:
        next_state = st_recv;
    endcase
  end

  assign tx_data = txd;
  assign tx_last = (state == st_tx) && last;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_recv;    ret <= st_recv;     ptr <= 9'h000;
      ovf <= 1'b0;         crc_rx <= `CRC_INIT; crc_tx <= `CRC_INIT;
      dev <= 8'h00;        fn <= 8'h00;        bcount <= 8'h00;
      start <= 16'h0000;   qty <= 16'h0000;    cur <= 9'h000;
      left <= 16'h0000;    word <= 16'h0000;   bitn <= 3'h0;
      hidx <= 3'h0;        hlen <= 3'h0;       acc <= 8'h00;
      bufp <= 8'h00;       b2 <= 8'h00;        exc <= 1'b0;
      last <= 1'b0;        txd <= 8'h00;
      dn <= '0;            dn_valid <= 1'b0;
    end
    else
    begin
      state <= next_state; ret <= next_ret;    ptr <= next_ptr;
      ovf <= next_ovf;     crc_rx <= next_crc_rx; crc_tx <= next_crc_tx;
      dev <= next_dev;     fn <= next_fn;      bcount <= next_bcount;
      start <= next_start; qty <= next_qty;    cur <= next_cur;
      left <= next_left;   word <= next_word;  bitn <= next_bitn;
      hidx <= next_hidx;   hlen <= next_hlen;  acc <= next_acc;
      bufp <= next_bufp;   b2 <= next_b2;      exc <= next_exc;
      last <= next_last;   txd <= next_txd;
      dn <= next_dn;       dn_valid <= next_dn_valid;
    end
  end

endmodule : modbus_map_access

// *** core/modbus_map_params.svh ***
// Constants for the mapping area request interpreter.
// Assumes inclusion by bare name from the design files.
`ifndef MODBUS_MAP_PARAMS_SVH
`define MODBUS_MAP_PARAMS_SVH

// ----------------------------------------------------------------
// Mapping areas
// ----------------------------------------------------------------
`define AREA_BASE        16'h0064
`define AREA_LIMIT       16'h0190
`define AREA_DEPTH       300
`define RX_DEPTH         256

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define POS_DEV          9'h000
`define POS_FN           9'h001
`define POS_START_HI     9'h002
`define POS_START_LO     9'h003
`define POS_QTY_HI       9'h004
`define POS_QTY_LO       9'h005
`define POS_BCOUNT       9'h006
`define DATA_START       8'h07
`define FIXED_LEN        9'h008
`define MULTI_OVERHEAD   9'h009
`define MIN_LEN          9'h004
`define HEAD_SHORT       3'h3
`define HEAD_LONG        3'h6

// ----------------------------------------------------------------
// Function codes, values, exceptions
// ----------------------------------------------------------------
`define FN_READ_BITS     8'h01
`define FN_READ_WORDS    8'h03
`define FN_WRITE_BIT     8'h05
`define FN_WRITE_WORD    8'h06
`define FN_WRITE_BITS    8'h0F
`define FN_WRITE_WORDS   8'h10
`define COIL_ON          16'hFF00
`define COIL_OFF         16'h0000
`define EXC_FLAG         8'h80
`define EXC_NONE         8'h00
`define EXC_FUNC         8'h01
`define EXC_ADDR         8'h02
`define EXC_VALUE        8'h03
`define DEV_ADDR_MIN     8'h01
`define DEV_ADDR_MAX     8'hF7
`define MAX_READ_BITS    16'h07D0
`define MAX_READ_WORDS   16'h007D
`define MAX_WRITE_BITS   16'h07B0
`define MAX_WRITE_WORDS  16'h007B

// ----------------------------------------------------------------
// Frame check
// ----------------------------------------------------------------
`define CRC_INIT         16'hFFFF
`define CRC_POLY         16'hA001

`endif

// *** core/modbus_map_pkg.sv ***
// Types shared by the mapping area request interpreter.
// Assumes nothing beyond a SystemVerilog compiler.
package modbus_map_pkg;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_recv, st_check, st_head, st_bits, st_words, st_wlo,
    st_wbit, st_wword, st_crcl, st_crch, st_tx
  } state_t;

  // ----------------------------------------------------------------
  // Area write carrier (poll updates and downstream writes)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        is_bit;
    logic [8:0]  index;
    logic [15:0] value;
  } area_wr_t;

endpackage : modbus_map_pkg

// *** core/crc16_byte.sv ***
// One byte step of the frame check sequence.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`include "modbus_map_params.svh"

module crc16_byte
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc_out
);

  // ----------------------------------------------------------------
  // Reflected shift, eight bits per call
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end

endmodule : crc16_byte

// *** core/map_memory.sv ***
// Simple dual port storage with registered read data.
// Assumes one writer and one reader in the clock domain of clk.
`timescale 1ns/1ns

module map_memory
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 300,
  parameter int AW    = 9
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage; contents are not reset, only the read register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_en && (int'(wr_addr) < DEPTH))
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data <= '0;
    else if (int'(rd_addr) < DEPTH)
      rd_data <= mem[rd_addr];
    else
      rd_data <= '0;
  end

endmodule : map_memory

// *** verif/modbus_map_access_assertions.sv ***
// Port assertions for the mapping area interpreter.
// Assumes the bind below; sees only the interpreter's ports.
`timescale 1ns/1ns
`include "modbus_map_params.svh"

module modbus_map_access_assertions
  import modbus_map_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [7:0]             own_addr,
  input wire logic [`AREA_DEPTH-1:0] coil_mapped,
  input wire logic [`AREA_DEPTH-1:0] reg_mapped,
  input wire logic                   rx_valid,
  input wire logic [7:0]             rx_data,
  input wire logic                   rx_end,
  input wire logic                   tx_valid,
  input wire logic [7:0]             tx_data,
  input wire logic                   tx_last,
  input wire logic                   tx_ready,
  input wire area_wr_t               upd,
  input wire logic                   upd_valid,
  input wire logic                   upd_ready,
  input wire area_wr_t               dn,
  input wire logic                   dn_valid
);
  // ------
  // Frame tracking
  // ------
  logic       at_start, next_at_start, in_reply, next_in_reply;
  logic [7:0] first, next_first;

  always_comb
  begin
    next_at_start = rx_end || (at_start && !rx_valid);
    next_first    = (rx_valid && at_start) ? rx_data : first;
    next_in_reply = tx_valid ? !(tx_ready && tx_last) : in_reply;
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      {at_start, first, in_reply} <= {1'b1, 8'h00, 1'b0};
    else
      {at_start, first, in_reply} <= {next_at_start, next_first, next_in_reply};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_own_addr:
    assert property (tx_valid && !in_reply |-> tx_data == own_addr) else $error("bad address");
  a_stall_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("moved");
  a_last_valid:
    assert property (tx_last |-> tx_valid) else $error("last without valid");
  a_end_gap:
    assert property (tx_valid && tx_ready && tx_last |=> !tx_valid [*3]) else $error("early");
  a_foreign_quiet:
    assert property (rx_end && !at_start && first != own_addr |=> !tx_valid [*8])
    else $error("reply to foreign frame");
  a_dn_bit:
    assert property (dn_valid && dn.is_bit |-> dn.value[15:1] == 15'h0000) else $error("wide");
  a_dn_mapped:
    assert property (dn_valid |-> (dn.is_bit ? coil_mapped[dn.index] : reg_mapped[dn.index]))
    else $error("unmapped write");
  a_dn_area:
    assert property (dn_valid |-> dn.index < 9'h12c) else $error("outside area");
  a_dn_cause:
    assert property (dn_valid |-> !$past(upd_ready)) else $error("write without area update");

endmodule : modbus_map_access_assertions

bind modbus_map_access modbus_map_access_assertions u_chk
(
  .clk(clk), .rst(rst), .own_addr(own_addr), .coil_mapped(coil_mapped),
  .reg_mapped(reg_mapped), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
  .upd(upd), .upd_valid(upd_valid), .upd_ready(upd_ready), .dn(dn), .dn_valid(dn_valid)
);

// *** verif/modbus_master_model.sv ***
// Reply side of the Modbus master: takes reply bytes.
// Assumes the bench reads got and frames and sets slow.
`timescale 1ns/1ns

module modbus_master_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic [2:0] tick;
  int         frames;

  // Stalls half the time when slow, like a busy host
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      tick     <= 3'h0;
      tx_ready <= 1'b0;
      frames   <= 0;
    end
    else
    begin
      tick     <= tick + 3'h1;
      tx_ready <= !slow || tick[1];
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
      if (tx_valid && tx_ready && tx_last)
        frames <= frames + 1;
    end

endmodule : modbus_master_model

// *** verif/modbus_map_access_bench.sv ***
// Bench for the mapping area interpreter: random and corner requests.
// Assumes the master model on the reply side and the bound checker.
`timescale 1ns/1ns
`include "modbus_map_params.svh"

module modbus_map_access_bench
  import modbus_map_pkg::*;
;
  logic                   clk, rst, rx_valid, rx_end, upd_valid, slow;
  logic                   tx_valid, tx_last, tx_ready, upd_ready, dn_valid;
  logic [7:0]             own_addr, rx_data, tx_data;
  logic [`AREA_DEPTH-1:0] coil_mapped, reg_mapped;
  area_wr_t               upd, dn;
  area_wr_t               dnq[$];
  logic                   bits[300];
  logic [15:0]            words[300];
  logic [7:0]             req[$], resp[$];
  logic [31:0]            lf;
  int                     n_mismatch, n_compared, s, n;
  int                     edge_s[3] = '{399, 392, 102};
  int                     edge_n[3] = '{1, 8, 298};

  modbus_map_access u_dut
  (
    .clk(clk), .rst(rst), .own_addr(own_addr), .coil_mapped(coil_mapped),
    .reg_mapped(reg_mapped), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .upd(upd), .upd_valid(upd_valid), .upd_ready(upd_ready), .dn(dn), .dn_valid(dn_valid)
  );
  modbus_master_model u_master
  (
    .clk(clk), .rst(rst), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready)
  );

  always #2 clk = ~clk;
  always @(posedge clk)
    if (dn_valid === 1'b1)
      dnq.push_back(dn);

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask : seal

  task automatic chk(input string what, input logic [25:0] e, input logic [25:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic put(input logic b, input int i, input logic [15:0] v);
    upd       = {b, 9'(i), v};
    upd_valid = 1'b1;
    chk("update ready", 26'h1, 26'(upd_ready));
    @(negedge clk);
  endtask : put

  // Sends req, then waits a bounded time for a whole reply
  task automatic xact(input string what, input logic want);
    int k;
    int f;
    u_master.got.delete();
    dnq.delete();
    f = u_master.frames;
    foreach (req[i])
    begin
      rx_valid = 1'b1;
      rx_data  = req[i];
      rx_end   = (i == req.size() - 1);
      @(negedge clk);
    end
    {rx_valid, rx_end} = 2'h0;
    for (k = 0; k < 1000 && u_master.frames == f; k++)
      @(negedge clk);
    chk({what, " len"}, want ? 26'(resp.size()) : 26'h0, 26'(u_master.got.size()));
    for (int i = 0; want && i < resp.size(); i++)
      chk(what, 26'(resp[i]), 26'(u_master.got[i]));
    $display("test %s done", what);
    if (want && k == 1000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : xact

  task automatic rd(input logic [7:0] fn, input int s, input int n);
    logic [7:0] b;
    req = {own_addr, fn, 8'(s >> 8), 8'(s), 8'(n >> 8), 8'(n)};
    seal(req);
    resp = {own_addr, fn, 8'(fn == 8'h01 ? (n + 7) / 8 : 2 * n)};
    b = 8'h00;
    for (int k = 0; k < n; k++)
      if (fn == 8'h03)
        resp = {resp, words[s - 100 + k][15:8], words[s - 100 + k][7:0]};
      else
      begin
        b[k % 8] = bits[s - 100 + k];
        if (k % 8 == 7 || k == n - 1)
        begin
          resp.push_back(b);
          b = 8'h00;
        end
      end
    seal(resp);
  endtask : rd

  task automatic wr_coil(input int a, input logic [15:0] v);
    req = {own_addr, 8'h05, 8'(a >> 8), 8'(a), v[15:8], v[7:0]};
    seal(req);
    resp = req;
    xact("coil write", 1'b1);
    chk("write count", 26'(coil_mapped[a - 100]), 26'(dnq.size()));
    if (dnq.size() > 0)
      chk("write", {1'b1, 9'(a - 100), 15'h0000, v == 16'hff00}, dnq[0]);
  endtask : wr_coil

  // Refused request: expects the flagged function and the reason code
  task automatic bad_req(input logic [7:0] fn, input int s, input logic [7:0] code);
    req = {own_addr, fn, 8'(s >> 8), 8'(s), 8'h00, 8'h02};
    seal(req);
    resp = {own_addr, fn | 8'h80, code};
    seal(resp);
    xact("exception", 1'b1);
  endtask : bad_req

  // ------
  // Sequence
  // ------
  initial
  begin
    {clk, rst, rx_valid, rx_end, upd_valid, slow} = 6'h10;
    {rx_data, upd, n_mismatch, n_compared} = '0;
    lf = 32'h0000_068e;
    for (int i = 0; i < 300; i++)
    begin
      lf = lfsr(lf);
      {coil_mapped[i], reg_mapped[i], bits[i]} = lf[2:0];
      words[i] = lf[31:16];
    end
    coil_mapped[1:0] = 2'h1;
    reg_mapped[0] = 1'b1;
    own_addr = 8'(lf % 246) + 8'h01;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 300; i++)
      put(1'b1, i, {15'h0000, bits[i]});
    for (int i = 0; i < 16; i++)
      put(1'b0, i, words[i]);
    upd_valid = 1'b0;
    @(negedge clk);
    foreach (edge_s[i])
    begin
      rd(8'h01, edge_s[i], edge_n[i]);
      xact("edge bit read", 1'b1);
    end
    for (int t = 0; t < 12; t++)
    begin
      lf   = lfsr(lf);
      n    = int'(lf[4:0]) + 1;
      s    = 102 + int'(lf[15:8]) % (299 - n);
      slow = lf[20];
      rd(8'h01, s, n);
      xact("random bit read", 1'b1);
    end
    slow = 1'b1;
    rd(8'h03, 102, 8);
    xact("word read", 1'b1);
    // Writes stay on 100 and 101, which are never read back
    wr_coil(100, 16'hff00);
    wr_coil(101, 16'hff00);
    wr_coil(100, 16'h0000);
    req = {own_addr, 8'h06, 8'h00, 8'h64, 8'h12, 8'h34};
    seal(req);
    resp = req;
    xact("word write", 1'b1);
    chk("word write count", 26'h1, 26'(dnq.size()));
    if (dnq.size() > 0)
      chk("word write", {1'b0, 9'h000, 16'h1234}, dnq[0]);
    bad_req(8'h01, 399, 8'h02);
    bad_req(8'h02, 102, 8'h01);
    req = {own_addr + 8'h01, 8'h01, 8'h00, 8'h66, 8'h00, 8'h08};
    seal(req);
    xact("foreign address", 1'b0);
    rd(8'h01, 102, 8);
    req[6] = ~req[6];
    xact("bad check", 1'b0);
    rd(8'h01, 102, 3);
    xact("after drops", 1'b1);
    report_and_stop();
  end

endmodule : modbus_map_access_bench
